// ### logic/lsp_pkg.sv
// package: constants and types shared by the legacy sideband power-state logic
package lsp_pkg;

  // ==========================================================================
  // synchroniser lanes, one per asynchronous sideband input
  // ==========================================================================
  localparam int unsigned LSP_SYNC_W      = 6;
  localparam int unsigned LSP_IDX_SYSMGMT = 0;
  localparam int unsigned LSP_IDX_STOPCLK = 1;
  localparam int unsigned LSP_IDX_PROBE   = 2;
  localparam int unsigned LSP_IDX_SLEEP   = 3;
  localparam int unsigned LSP_IDX_DEEP    = 4;
  localparam int unsigned LSP_IDX_DEEPER  = 5;
  // all active-low inputs idle high, so the flops reset to all ones
  localparam logic [LSP_SYNC_W-1:0] LSP_SYNC_RST = 6'h3F;

  // ==========================================================================
  // host bus acknowledge transaction codes
  // ==========================================================================
  localparam int unsigned LSP_ACK_W = 2;
  localparam logic [LSP_ACK_W-1:0] LSP_ACK_NONE      = 2'h0;
  localparam logic [LSP_ACK_W-1:0] LSP_ACK_SYS_MGMT  = 2'h1;
  localparam logic [LSP_ACK_W-1:0] LSP_ACK_STOP_GRNT = 2'h2;

  // ==========================================================================
  // power / mode state machine, gray coded along run -> stop-grant -> deeper
  // ==========================================================================
  typedef enum logic [2:0] {
    LSP_ST_RUN        = 3'h0,
    LSP_ST_SG_ACK     = 3'h1,
    LSP_ST_STOP_GRANT = 3'h3,
    LSP_ST_SLEEP      = 3'h2,
    LSP_ST_DEEP       = 3'h6,
    LSP_ST_DEEPER     = 3'h7,
    LSP_ST_SM_ACK     = 3'h4,
    LSP_ST_SYS_MGMT   = 3'h5
  } lsp_state_t;

  localparam logic LSP_ON  = 1'b1;
  localparam logic LSP_OFF = 1'b0;

endpackage

// ### logic/lsp_sync.sv
// two-flop synchroniser bank for the asynchronous sideband inputs
`timescale 1ns/1ns
module lsp_sync
  import lsp_pkg::*;
#(
  parameter int unsigned            WIDTH   = LSP_SYNC_W,
  parameter logic [WIDTH-1:0]       RST_VAL = LSP_SYNC_RST
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  lsp_sync_if.sync  sif
);

  // ==========================================================================
  // stages
  // ==========================================================================
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d   = clk_en_i ? sif.async_lvl : meta_q;
    stable_d = clk_en_i ? meta_q : stable_q;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q   <= RST_VAL;
      stable_q <= RST_VAL;
    end else begin
      meta_q   <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sif.sync_lvl = stable_q;

endmodule

// ### logic/lsp_sync_if.sv
// interface: raw asynchronous sideband levels in, synchronised levels out
`timescale 1ns/1ns
interface lsp_sync_if #(
  parameter int unsigned WIDTH = 6
);
  logic [WIDTH-1:0] async_lvl;
  logic [WIDTH-1:0] sync_lvl;

  modport sync (input async_lvl, output sync_lvl);
  modport user (output async_lvl, input sync_lvl);
endinterface

// ### logic/lsp_top.sv
// legacy sideband power-state sequencer: system management, stop-grant, probe, sleep levels
// Summary of operation
// - system management interrupt low moves the device into system management mode
// - acknowledge transaction for that interrupt goes out before the handler starts
// - stop-clock request enters stop-grant and issues a stop-grant acknowledge
// - in stop-grant core clocks gate; bus unit and interrupt controller stay clocked
// - in stop-grant bus snooping continues; a system management interrupt is latched and taken after return to run
// - stop-clock release re-enables all clocks and resumes execution
// - stop-clock is asynchronous and never touches the bus clock
// - probe request is answered by probe-ready only once probe mode is entered
// - when enabled, probe request wakes the core from C4 or C6
// - deep-sleep request moves sleep to deep sleep; release returns to sleep
// - deeper-sleep request moves deep to deeper sleep; release returns to deep
// - pending-break-event stays deasserted while stop-clock has been deasserted for three or more cycles
`timescale 1ns/1ns
module lsp_top
  import lsp_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 sys_mgmt_interrupt_n_i,
  input  wire logic                 stop_clock_req_n_i,
  input  wire logic                 probe_request_n_i,
  input  wire logic                 sleep_req_n_i,
  input  wire logic                 deep_sleep_req_n_i,
  input  wire logic                 deeper_sleep_req_n_i,
  input  wire logic                 probe_wake_en_i,
  input  wire logic                 core_deep_cstate_i,
  input  wire logic                 break_event_i,
  input  wire logic                 sys_mgmt_exit_i,
  input  wire logic                 probe_exit_i,
  input  wire logic                 bus_ack_ready_i,
  output logic                      bus_ack_valid_o,
  output logic [LSP_ACK_W-1:0]      bus_ack_type_o,
  output logic                      sys_mgmt_mode_o,
  output logic                      sys_mgmt_handler_start_o,
  output logic                      core_clk_en_o,
  output logic                      bus_unit_clk_en_o,
  output logic                      lic_clk_en_o,
  output logic                      snoop_en_o,
  output logic                      probe_ready_n_o,
  output logic                      probe_wake_o,
  output logic                      pending_break_event_n_o,
  output lsp_state_t                power_state_o
);

  // ==========================================================================
  // input synchronisation
  // ==========================================================================
  lsp_sync_if #(.WIDTH(LSP_SYNC_W)) sif ();

  always_comb begin
    sif.async_lvl                  = LSP_SYNC_RST;
    sif.async_lvl[LSP_IDX_SYSMGMT] = sys_mgmt_interrupt_n_i;
    sif.async_lvl[LSP_IDX_STOPCLK] = stop_clock_req_n_i;
    sif.async_lvl[LSP_IDX_PROBE]   = probe_request_n_i;
    sif.async_lvl[LSP_IDX_SLEEP]   = sleep_req_n_i;
    sif.async_lvl[LSP_IDX_DEEP]    = deep_sleep_req_n_i;
    sif.async_lvl[LSP_IDX_DEEPER]  = deeper_sleep_req_n_i;
  end

  lsp_sync #(
    .WIDTH   (LSP_SYNC_W),
    .RST_VAL (LSP_SYNC_RST)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .sif       (sif)
  );

  // active-high views of the synchronised levels
  logic sm_req;
  logic stop_req;
  logic probe_req;
  logic sleep_req;
  logic deep_req;
  logic deeper_req;

  always_comb begin
    sm_req     = ~sif.sync_lvl[LSP_IDX_SYSMGMT];
    stop_req   = ~sif.sync_lvl[LSP_IDX_STOPCLK];
    probe_req  = ~sif.sync_lvl[LSP_IDX_PROBE];
    sleep_req  = ~sif.sync_lvl[LSP_IDX_SLEEP];
    deep_req   = ~sif.sync_lvl[LSP_IDX_DEEP];
    deeper_req = ~sif.sync_lvl[LSP_IDX_DEEPER];
  end

  // ==========================================================================
  // system management request capture
  // ==========================================================================
  // latched on the falling edge so a short pulse is not lost while the
  // machine is busy acknowledging a stop-grant
  logic sm_prev_q;
  logic sm_prev_d;
  logic sm_pend_q;
  logic sm_pend_d;
  logic sm_take;

  always_comb begin
    sm_prev_d = sm_prev_q;
    sm_pend_d = sm_pend_q;
    if (clk_en_i) begin
      sm_prev_d = sm_req;
      if (sm_take) begin
        sm_pend_d = LSP_OFF;
      end
      // set wins over clear
      if (sm_req && !sm_prev_q) begin
        sm_pend_d = LSP_ON;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sm_prev_q <= LSP_OFF;
      sm_pend_q <= LSP_OFF;
    end else begin
      sm_prev_q <= sm_prev_d;
      sm_pend_q <= sm_pend_d;
    end
  end

  // ==========================================================================
  // power / mode state machine
  // ==========================================================================
  lsp_state_t state_q;
  lsp_state_t state_d;
  logic       handler_start;

  always_comb begin
    state_d       = state_q;
    sm_take       = LSP_OFF;
    handler_start = LSP_OFF;
    if (clk_en_i) begin
      case (state_q)
        LSP_ST_RUN: begin
          if (sm_pend_q) begin
            state_d = LSP_ST_SM_ACK;
            sm_take = LSP_ON;
          end else if (stop_req) begin
            state_d = LSP_ST_SG_ACK;
          end
        end
        LSP_ST_SM_ACK: begin
          // handler waits for the acknowledge to leave the bus
          if (bus_ack_ready_i) begin
            state_d       = LSP_ST_SYS_MGMT;
            handler_start = LSP_ON;
          end
        end
        LSP_ST_SYS_MGMT: begin
          if (sys_mgmt_exit_i) begin
            state_d = LSP_ST_RUN;
          end
        end
        LSP_ST_SG_ACK: begin
          if (bus_ack_ready_i) begin
            state_d = LSP_ST_STOP_GRANT;
          end
        end
        LSP_ST_STOP_GRANT: begin
          if (!stop_req) begin
            state_d = LSP_ST_RUN;
          end else if (sleep_req) begin
            state_d = LSP_ST_SLEEP;
          end
        end
        LSP_ST_SLEEP: begin
          if (deep_req) begin
            state_d = LSP_ST_DEEP;
          end else if (!sleep_req) begin
            state_d = LSP_ST_STOP_GRANT;
          end
        end
        LSP_ST_DEEP: begin
          if (deeper_req) begin
            state_d = LSP_ST_DEEPER;
          end else if (!deep_req) begin
            state_d = LSP_ST_SLEEP;
          end
        end
        LSP_ST_DEEPER: begin
          if (!deeper_req) begin
            state_d = LSP_ST_DEEP;
          end
        end
        default: begin
          state_d = LSP_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= LSP_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // probe mode
  // ==========================================================================
  // probe entry needs the run state and no deep c-state; a deep c-state core is woken only if probe_wake_en_i is set
  logic probe_mode_q;
  logic probe_mode_d;
  logic wake_d;

  always_comb begin
    probe_mode_d = probe_mode_q;
    wake_d       = LSP_OFF;
    if (clk_en_i) begin
      if (probe_mode_q) begin
        if (probe_exit_i || !probe_req) begin
          probe_mode_d = LSP_OFF;
        end
      end else if (probe_req) begin
        if (core_deep_cstate_i) begin
          wake_d = probe_wake_en_i;
        end else if (state_q == LSP_ST_RUN) begin
          probe_mode_d = LSP_ON;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      probe_mode_q <= LSP_OFF;
    end else begin
      probe_mode_q <= probe_mode_d;
    end
  end

  // ==========================================================================
  // registered outputs
  // ==========================================================================
  logic             ack_valid_d;
  logic [LSP_ACK_W-1:0] ack_type_d;
  logic             pbe_n_d;
  logic             core_clk_d;

  always_comb begin
    ack_valid_d = LSP_OFF;
    ack_type_d  = LSP_ACK_NONE;
    if (state_d == LSP_ST_SM_ACK) begin
      ack_valid_d = LSP_ON;
      ack_type_d  = LSP_ACK_SYS_MGMT;
    end else if (state_d == LSP_ST_SG_ACK) begin
      ack_valid_d = LSP_ON;
      ack_type_d  = LSP_ACK_STOP_GRNT;
    end
    // core clocks stop once the acknowledge is out, back on at release
    core_clk_d = !(state_d inside {LSP_ST_STOP_GRANT, LSP_ST_SLEEP,
                                   LSP_ST_DEEP, LSP_ST_DEEPER});
    pbe_n_d    = !(stop_req && break_event_i);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bus_ack_valid_o          <= LSP_OFF;
      bus_ack_type_o           <= LSP_ACK_NONE;
      sys_mgmt_mode_o          <= LSP_OFF;
      sys_mgmt_handler_start_o <= LSP_OFF;
      core_clk_en_o            <= LSP_ON;
      bus_unit_clk_en_o        <= LSP_ON;
      lic_clk_en_o             <= LSP_ON;
      snoop_en_o               <= LSP_ON;
      probe_ready_n_o          <= LSP_ON;
      probe_wake_o             <= LSP_OFF;
      pending_break_event_n_o  <= LSP_ON;
      power_state_o            <= LSP_ST_RUN;
    end else if (clk_en_i) begin
      bus_ack_valid_o          <= ack_valid_d;
      bus_ack_type_o           <= ack_type_d;
      sys_mgmt_mode_o          <= (state_d == LSP_ST_SYS_MGMT);
      sys_mgmt_handler_start_o <= handler_start;
      core_clk_en_o            <= core_clk_d;
      // bus unit and interrupt controller keep their clocks in every state
      bus_unit_clk_en_o        <= LSP_ON;
      lic_clk_en_o             <= LSP_ON;
      snoop_en_o               <= LSP_ON;
      probe_ready_n_o          <= !probe_mode_d;
      probe_wake_o             <= wake_d;
      pending_break_event_n_o  <= pbe_n_d;
      power_state_o            <= state_d;
    end
  end

endmodule

// ### tb/lsp_chipset_model.sv
// partner: host bus side that accepts acknowledge transactions after a set wait
`timescale 1ns/1ns
module lsp_chipset_model (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       ack_valid_i,
  input  wire logic [3:0] wait_i,
  output logic            bus_ack_ready_o
);
  logic [3:0] cnt_q;
  // ==========================================================================
  // ready rises after wait_i+1 cycles of valid, drops once the ack is taken
  // ==========================================================================
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 4'h0;
      bus_ack_ready_o <= 1'b0;
    end else if (ack_valid_i && !bus_ack_ready_o) begin
      cnt_q <= cnt_q + 4'h1;
      bus_ack_ready_o <= (cnt_q >= wait_i);
    end else begin
      cnt_q <= 4'h0;
      bus_ack_ready_o <= 1'b0;
    end
  end
endmodule

// ### tb/lsp_monitor.sv
// checker: concurrent properties on the sideband sequencer ports
`timescale 1ns/1ns
module lsp_monitor
  import lsp_pkg::*;
(
  input wire logic                 clk_sys_i,
  input wire logic                 reset_i,
  input wire logic                 stop_clock_req_n_i,
  input wire logic                 probe_request_n_i,
  input wire logic                 bus_ack_ready_i,
  input wire logic                 bus_ack_valid_o,
  input wire logic [LSP_ACK_W-1:0] bus_ack_type_o,
  input wire logic                 sys_mgmt_mode_o,
  input wire logic                 sys_mgmt_handler_start_o,
  input wire logic                 core_clk_en_o,
  input wire logic                 bus_unit_clk_en_o,
  input wire logic                 lic_clk_en_o,
  input wire logic                 snoop_en_o,
  input wire logic                 probe_ready_n_o,
  input wire logic                 pending_break_event_n_o,
  input wire lsp_state_t           power_state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // acknowledge and handler entry
  // ==========================================================================
  ack_hold_a: assert property (bus_ack_valid_o && !bus_ack_ready_i |=>
    bus_ack_valid_o && $stable(bus_ack_type_o)) else $error("ack dropped early");
  handler_entry_a: assert property (bus_ack_valid_o && bus_ack_ready_i &&
    bus_ack_type_o == LSP_ACK_SYS_MGMT |=> sys_mgmt_handler_start_o && sys_mgmt_mode_o)
    else $error("handler not started after ack");
  mode_after_ack_a: assert property ($rose(sys_mgmt_mode_o) |->
    $past(bus_ack_valid_o) && $past(bus_ack_ready_i)) else $error("mode without ack");
  start_pulse_a: assert property (sys_mgmt_handler_start_o |=>
    !sys_mgmt_handler_start_o) else $error("start longer than one cycle");
  // ==========================================================================
  // clocks and stop-grant
  // ==========================================================================
  grant_gated_a: assert property (power_state_o inside {LSP_ST_STOP_GRANT, LSP_ST_SLEEP,
    LSP_ST_DEEP, LSP_ST_DEEPER} |-> !core_clk_en_o) else $error("core clock running");
  units_live_a: assert property (bus_unit_clk_en_o && lic_clk_en_o && snoop_en_o)
    else $error("bus or interrupt unit stopped");
  run_clocked_a: assert property (power_state_o == LSP_ST_RUN |-> core_clk_en_o)
    else $error("core clock off in run");
  pbe_idle_a: assert property (stop_clock_req_n_i [*4] |=> pending_break_event_n_o)
    else $error("break event without stop");
  sync_lag_a: assert property ($rose(bus_ack_valid_o) &&
    bus_ack_type_o == LSP_ACK_STOP_GRNT |-> !$past(stop_clock_req_n_i, 3))
    else $error("stop taken without two flops");
  deeper_step_a: assert property (power_state_o == LSP_ST_DEEPER |->
    $past(power_state_o) inside {LSP_ST_DEEP, LSP_ST_DEEPER}) else $error("deeper skipped deep");
  probe_ready_a: assert property ($fell(probe_ready_n_o) |->
    !$past(probe_request_n_i, 2)) else $error("ready without request");
  cover property (sys_mgmt_handler_start_o);
  cover property (power_state_o == LSP_ST_STOP_GRANT);
  cover property (power_state_o == LSP_ST_DEEPER);
endmodule
bind lsp_top lsp_monitor u_lsp_monitor (.clk_sys_i, .reset_i, .stop_clock_req_n_i,
  .probe_request_n_i, .bus_ack_ready_i, .bus_ack_valid_o, .bus_ack_type_o, .sys_mgmt_mode_o,
  .sys_mgmt_handler_start_o, .core_clk_en_o, .bus_unit_clk_en_o, .lic_clk_en_o, .snoop_en_o,
  .probe_ready_n_o, .pending_break_event_n_o, .power_state_o);

// ### tb/lsp_tb_top.sv
// testbench: directed scenarios for the sideband power-state sequencer
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module lsp_tb_top;
  import lsp_pkg::*;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, smi_n = 1'b1, stop_n = 1'b1, prb_n = 1'b1;
  logic slp_n = 1'b1, dp_n = 1'b1, dpr_n = 1'b1, wake_en = 1'b0, cst = 1'b0;
  logic brk = 1'b0, sm_exit = 1'b0, rdy, vld, mode, start, core, busc, licc, snp, probe_ready_n_n;
  logic wake, pbe_n, clk_en = 1'b1, prb_exit = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic [LSP_ACK_W-1:0] typ;
  lsp_state_t st;
  int miscompares = 0, compares = 0, cycles = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  lsp_top u_lsp_top (.clk_sys_i, .reset_i, .clk_en_i(clk_en), .sys_mgmt_interrupt_n_i(smi_n),
    .stop_clock_req_n_i(stop_n), .probe_request_n_i(prb_n), .sleep_req_n_i(slp_n),
    .deep_sleep_req_n_i(dp_n), .deeper_sleep_req_n_i(dpr_n), .probe_wake_en_i(wake_en),
    .core_deep_cstate_i(cst), .break_event_i(brk), .sys_mgmt_exit_i(sm_exit),
    .probe_exit_i(prb_exit), .bus_ack_ready_i(rdy), .bus_ack_valid_o(vld), .bus_ack_type_o(typ),
    .sys_mgmt_mode_o(mode), .sys_mgmt_handler_start_o(start), .core_clk_en_o(core),
    .bus_unit_clk_en_o(busc), .lic_clk_en_o(licc), .snoop_en_o(snp), .probe_ready_n_o(probe_ready_n_n),
    .probe_wake_o(wake), .pending_break_event_n_o(pbe_n), .power_state_o(st));
  lsp_chipset_model u_lsp_chipset_model (.clk_sys_i, .reset_i, .ack_valid_i(vld),
    .wait_i(ack_wait), .bus_ack_ready_o(rdy));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_smi;
    ack_wait = 4'h3;
    smi_n = 1'b0;
    // two sync flops plus the falling-edge latch before the ack goes out
    cyc(4);
    `CHK("ack_valid", 1'b1, vld)
    `CHK("ack_type", LSP_ACK_SYS_MGMT, typ)
    `CHK("mode_early", 1'b0, mode)
    repeat (20) if (!start) cyc(1);
    `CHK("start", 1'b1, start)
    `CHK("mode", 1'b1, mode)
    `CHK("sm_state", LSP_ST_SYS_MGMT, st)
    smi_n = 1'b1;
    sm_exit = 1'b1;
    cyc(1);
    sm_exit = 1'b0;
    `CHK("mode_exit", 1'b0, mode)
  endtask
  task automatic t_stop;
    ack_wait = 4'h0;
    brk = 1'b1;
    stop_n = 1'b0;
    cyc(3);
    `CHK("sg_type", LSP_ACK_STOP_GRNT, typ)
    repeat (20) if (vld) cyc(1);
    `CHK("sg_state", LSP_ST_STOP_GRANT, st)
    `CHK("core_off", 1'b0, core)
    `CHK("units_on", 3'h7, {busc, licc, snp})
    `CHK("pbe_on", 1'b0, pbe_n)
    stop_n = 1'b1;
    cyc(3);
    `CHK("core_on", 1'b1, core)
    `CHK("run", LSP_ST_RUN, st)
    `CHK("pbe_off", 1'b1, pbe_n)
    brk = 1'b0;
  endtask
  task automatic t_sleep;
    stop_n = 1'b0;
    repeat (20) if (st !== LSP_ST_STOP_GRANT) cyc(1);
    dpr_n = 1'b0;
    slp_n = 1'b0;
    cyc(3);
    `CHK("deeper_refused", LSP_ST_SLEEP, st)
    dpr_n = 1'b1;
    dp_n = 1'b0;
    cyc(3);
    `CHK("deep", LSP_ST_DEEP, st)
    dpr_n = 1'b0;
    cyc(3);
    `CHK("deeper", LSP_ST_DEEPER, st)
    dpr_n = 1'b1;
    cyc(3);
    `CHK("back_deep", LSP_ST_DEEP, st)
    dp_n = 1'b1;
    cyc(3);
    `CHK("back_sleep", LSP_ST_SLEEP, st)
    slp_n = 1'b1;
    stop_n = 1'b1;
    cyc(6);
    `CHK("wake_run", LSP_ST_RUN, st)
  endtask
  task automatic t_probe;
    prb_n = 1'b0;
    cyc(3);
    `CHK("probe_ready_n", 1'b0, probe_ready_n_n)
    prb_exit = 1'b1;
    cyc(1);
    `CHK("probe_ready_n_exit", 1'b1, probe_ready_n_n)
    prb_exit = 1'b0;
    prb_n = 1'b1;
    cyc(3);
    `CHK("probe_ready_n_off", 1'b1, probe_ready_n_n)
    cst = 1'b1;
    wake_en = 1'b1;
    prb_n = 1'b0;
    cyc(3);
    `CHK("wake", 1'b1, wake)
    `CHK("no_probe_ready_n", 1'b1, probe_ready_n_n)
    wake_en = 1'b0;
    cyc(1);
    `CHK("wake_off", 1'b0, wake)
    prb_n = 1'b1;
    // core stays in deep c-state until the request has drained from the flops
    cyc(3);
    cst = 1'b0;
  endtask
  task automatic t_hold;
    clk_en = 1'b0;
    stop_n = 1'b0;
    cyc(4);
    `CHK("frozen", LSP_ST_RUN, st)
    `CHK("frozen_ack", 1'b0, vld)
    clk_en = 1'b1;
    cyc(3);
    `CHK("thawed_ack", LSP_ACK_STOP_GRNT, typ)
    reset_i = 1'b1;
    stop_n = 1'b1;
    cyc(1);
    `CHK("rst_ack", 1'b0, vld)
    `CHK("rst_core", 1'b1, core)
    reset_i = 1'b0;
    cyc(3);
    `CHK("rst_run", LSP_ST_RUN, st)
    `CHK("rst_pbe", 1'b1, pbe_n)
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    cyc(3);
    reset_i = 1'b0;
    cyc(1);
    t_smi();
    t_stop();
    t_sleep();
    t_probe();
    t_hold();
    end_sim();
  end
endmodule
